//--- rtl/atf_pkg.sv
package atf_pkg;
    // ----------------------------------------
    // register addresses on the three address pins
    // ----------------------------------------
    localparam logic [2:0] DA_DATA = 3'h0;
    localparam logic [2:0] DA_ERR_FEAT = 3'h1;
    localparam logic [2:0] DA_SCOUNT = 3'h2;
    localparam logic [2:0] DA_SNUM = 3'h3;
    localparam logic [2:0] DA_CYL_LO = 3'h4;
    localparam logic [2:0] DA_CYL_HI = 3'h5;
    localparam logic [2:0] DA_DEV_HEAD = 3'h6;
    localparam logic [2:0] DA_STAT_CMD = 3'h7;
    localparam logic [2:0] DA_ALT_CTL = 3'h6;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_ADDR_MARK = 0;
    localparam int ER_TRACK0 = 1;
    localparam int ER_ABORT = 2;
    localparam int ER_SECTOR_ID = 4;
    localparam int ER_UNCORR = 6;
    localparam int ER_CRC = 7;
    localparam logic [7:0] ER_USED = 8'hd7;
    localparam logic [7:0] ER_USED_MW = 8'h57;
    localparam int DH_LBA = 6;
    localparam int DH_DEV = 4;
    localparam int CTL_SRST = 2;
    localparam int CTL_IDIS = 1;
    // ----------------------------------------
    // reset values and command codes
    // ----------------------------------------
    localparam logic [7:0] TF_RESET = 8'h00;
    localparam logic [7:0] SC_RESET = 8'h01;
    localparam logic [7:0] DIAG_PASS = 8'h01;
    localparam logic [7:0] CMD_DMA_RD = 8'hc8;
    localparam logic [7:0] CMD_DMA_WR = 8'hca;
    // ----------------------------------------
    // timing and buffer
    // ----------------------------------------
    localparam int CLK_NS = 50;
    localparam int SETTLE_NS = 400;
    localparam int SETTLE_CYC = SETTLE_NS / CLK_NS;
    localparam int PRESENCE_US = 1000;
    localparam int PRESENCE_CYC = PRESENCE_US * 1000 / CLK_NS;
    localparam int FIFO_W = 16;
    localparam int FIFO_D = 32;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_DMA = 3'b100
    } atf_state_t;
endpackage

//--- rtl/atf_task_file.sv
// Function
// - activity signal asserted from command to completion
// - drive 1 announces presence after power-on
// - DMA request only when data can move
// - command block decode of eight addresses
// - control block: alternate status, device control
// - invalid or unused addresses leave bus floating
// - 16-bit data port through the buffer
// - error register valid with error bit; diagnostics
// - bit 0: data address mark missing
// - bit 1: track zero missing on recalibrate
// - bit 2: command aborted
// - bit 4: sector ID missing; 5, 3 unused
// - bit 6 uncorrectable, bit 7 CRC
// - features value selects set-features feature
// - sector count left after command
// - sector number or LBA bits 7-0
// - cylinder low or LBA bits 15-8
// - cylinder high or LBA bits 23-16
// - head bits or LBA 27-24, updated
// - device bit selects drive 0 or 1
// - bit 6 selects CHS or LBA
// - status bits valid within 400 ns
// - status read acknowledges interrupt, alternate not
// - interrupt driven only when selected and enabled
`timescale 1ns/1ps
module atf_fifo #(
    parameter int W = 16,
    parameter int D = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;
    assign in_ready_o = cnt_reg != (AW+1)'(D);
    assign out_valid_o = cnt_reg != '0;
    assign out_data_o = mem[rp_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp_reg] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module atf_task_file #(
    parameter int unsigned PRESENCE_CYC = atf_pkg::PRESENCE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs0_n_i,
    input wire logic cs1_n_i,
    input wire logic [2:0] da_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [15:0] dd_i,
    output logic [15:0] dd_o,
    output logic dd_oe_n_o,
    output logic iordy_o,
    output logic intrq_o,
    output logic intrq_oe_n_o,
    output logic dasp_o,
    output logic dasp_oe_n_o,
    output logic dmarq_o,
    input wire logic dmack_n_i,
    input wire logic drive1_i,
    output logic cmd_valid_o,
    output logic [7:0] cmd_code_o,
    output logic [7:0] feature_o,
    output logic [7:0] sect_cnt_o,
    output logic [7:0] sect_num_o,
    output logic [15:0] cyl_o,
    output logic [3:0] head_o,
    output logic lba_mode_o,
    output logic [27:0] lba_o,
    output logic srst_o,
    input wire logic eng_ready_i,
    input wire logic pio_req_i,
    input wire logic done_i,
    input wire logic [7:0] done_err_i,
    input wire logic [7:0] done_sc_i,
    input wire logic [7:0] done_sn_i,
    input wire logic [15:0] done_cyl_i,
    input wire logic [3:0] done_head_i,
    input wire logic [15:0] eng_rdata_i,
    input wire logic eng_rvalid_i,
    output logic eng_rready_o,
    output logic [15:0] eng_wdata_o,
    output logic eng_wvalid_o,
    input wire logic eng_wready_i
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    atf_pkg::atf_state_t state_reg;
    logic [7:0] err_reg, feat_reg, sc_reg, sn_reg, cl_reg, ch_reg;
    logic [7:0] dh_reg, ctl_reg, code_reg, status_w, rmux;
    logic [15:0] rdata_reg;
    logic rd_done_reg, wr_done_reg, rd_act, wr_act, rd_ok, wr_ok;
    logic rd_serve, wr_serve, sel_cmd, sel_ctl, data_acc, me;
    logic pend_reg, drive1_reg, strap_done_reg, dma_rd_reg;
    logic cmd_go, done_ok, busy_w, srst, err_sum_reg;
    logic [23:0] prs_cnt_reg;
    logic rf_valid, rf_pop, wf_ready, wf_push;
    logic [15:0] rf_data;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    assign sel_cmd = !cs0_n_i && cs1_n_i;
    assign sel_ctl = cs0_n_i && !cs1_n_i && da_i == atf_pkg::DA_ALT_CTL;
    assign me = dh_reg[atf_pkg::DH_DEV] == drive1_reg;
    assign data_acc = (sel_cmd && da_i == atf_pkg::DA_DATA)
        || (!dmack_n_i && state_reg == atf_pkg::ST_DMA);
    assign srst = ctl_reg[atf_pkg::CTL_SRST];
    assign rd_act = !rd_n_i && !rd_done_reg && (sel_cmd || sel_ctl
        || data_acc);
    assign wr_act = !wr_n_i && !wr_done_reg && (sel_cmd || sel_ctl
        || data_acc);
    assign rd_ok = !data_acc || rf_valid;
    assign wr_ok = !data_acc || wf_ready || !me;
    assign rd_serve = rd_act && rd_ok;
    assign wr_serve = wr_act && wr_ok;
    assign iordy_o = !(rd_act && !rd_ok) && !(wr_act && !wr_ok);
    assign rf_pop = rd_serve && data_acc;
    assign wf_push = wr_serve && data_acc && me;
    assign cmd_go = wr_serve && sel_cmd && da_i == atf_pkg::DA_STAT_CMD
        && me && state_reg == atf_pkg::ST_IDLE && !srst;
    assign done_ok = done_i && state_reg != atf_pkg::ST_IDLE;

    // ----------------------------------------
    // strobe tracking and read data
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_done_reg <= 1'b0;
            wr_done_reg <= 1'b0;
        end else begin
            rd_done_reg <= !rd_n_i && (rd_done_reg || rd_serve);
            wr_done_reg <= !wr_n_i && (wr_done_reg || wr_serve);
        end
    end

    always_comb begin
        rmux = 8'h00;
        if (sel_ctl) begin
            rmux = status_w;
        end else begin
            case (da_i)
                atf_pkg::DA_ERR_FEAT: rmux = err_reg;
                atf_pkg::DA_SCOUNT: rmux = sc_reg;
                atf_pkg::DA_SNUM: rmux = sn_reg;
                atf_pkg::DA_CYL_LO: rmux = cl_reg;
                atf_pkg::DA_CYL_HI: rmux = ch_reg;
                atf_pkg::DA_DEV_HEAD: rmux = dh_reg;
                atf_pkg::DA_STAT_CMD: rmux = status_w;
                default: rmux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 16'h0000;
        end else if (rd_serve) begin
            rdata_reg <= data_acc ? rf_data : {8'h00, rmux};
        end
    end
    assign dd_o = rdata_reg;
    assign dd_oe_n_o = !(!rd_n_i && rd_done_reg
        && (sel_cmd || sel_ctl || data_acc));

    // ----------------------------------------
    // task file registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            feat_reg <= atf_pkg::TF_RESET;
            sc_reg <= atf_pkg::SC_RESET;
            sn_reg <= atf_pkg::SC_RESET;
            cl_reg <= atf_pkg::TF_RESET;
            ch_reg <= atf_pkg::TF_RESET;
            dh_reg <= atf_pkg::TF_RESET;
        end else if (done_ok) begin
            sc_reg <= done_sc_i;
            sn_reg <= done_sn_i;
            cl_reg <= done_cyl_i[7:0];
            ch_reg <= done_cyl_i[15:8];
            dh_reg <= {dh_reg[7:4], done_head_i};
        end else if (wr_serve && sel_cmd && !data_acc) begin
            if (da_i == atf_pkg::DA_DEV_HEAD) begin
                dh_reg <= dd_i[7:0];
            end else if (me && state_reg == atf_pkg::ST_IDLE) begin
                case (da_i)
                    atf_pkg::DA_ERR_FEAT: feat_reg <= dd_i[7:0];
                    atf_pkg::DA_SCOUNT: sc_reg <= dd_i[7:0];
                    atf_pkg::DA_SNUM: sn_reg <= dd_i[7:0];
                    atf_pkg::DA_CYL_LO: cl_reg <= dd_i[7:0];
                    atf_pkg::DA_CYL_HI: ch_reg <= dd_i[7:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_reg <= atf_pkg::TF_RESET;
        end else if (wr_serve && sel_ctl) begin
            ctl_reg <= dd_i[7:0];
        end
    end

    // ----------------------------------------
    // command sequencing
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || srst) begin
            state_reg <= atf_pkg::ST_IDLE;
            code_reg <= atf_pkg::TF_RESET;
            dma_rd_reg <= 1'b0;
        end else begin
            case (state_reg)
                atf_pkg::ST_IDLE: begin
                    if (cmd_go) begin
                        code_reg <= dd_i[7:0];
                        dma_rd_reg <= dd_i[7:1] == atf_pkg::CMD_DMA_RD[7:1];
                        if (dd_i[7:2] == atf_pkg::CMD_DMA_RD[7:2]) begin
                            state_reg <= atf_pkg::ST_DMA;
                        end else begin
                            state_reg <= atf_pkg::ST_EXEC;
                        end
                    end
                end
                atf_pkg::ST_EXEC, atf_pkg::ST_DMA: begin
                    if (done_i) begin
                        state_reg <= atf_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= atf_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_valid_o <= 1'b0;
        end else begin
            cmd_valid_o <= cmd_go;
        end
    end

    // ----------------------------------------
    // error register and interrupt
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || srst) begin
            err_reg <= atf_pkg::DIAG_PASS;
            err_sum_reg <= 1'b0;
        end else if (done_ok) begin
            err_reg <= done_err_i & (state_reg == atf_pkg::ST_DMA ?
                atf_pkg::ER_USED_MW : atf_pkg::ER_USED);
            err_sum_reg <= (done_err_i & (state_reg == atf_pkg::ST_DMA ?
                atf_pkg::ER_USED_MW : atf_pkg::ER_USED)) != 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || srst) begin
            pend_reg <= 1'b0;
        end else if (done_ok) begin
            pend_reg <= 1'b1;
        end else if (rd_serve && sel_cmd
            && da_i == atf_pkg::DA_STAT_CMD) begin
            pend_reg <= 1'b0;
        end
    end
    assign intrq_o = pend_reg;
    assign intrq_oe_n_o = !(me && !ctl_reg[atf_pkg::CTL_IDIS]);

    // ----------------------------------------
    // status composition
    // ----------------------------------------
    assign busy_w = state_reg != atf_pkg::ST_IDLE && !pio_req_i;
    always_comb begin
        status_w = 8'h00;
        status_w[atf_pkg::ST_BUSY] = busy_w;
        status_w[atf_pkg::ST_READY] = eng_ready_i && !srst;
        status_w[atf_pkg::ST_DRQ] = state_reg == atf_pkg::ST_EXEC
            && pio_req_i;
        status_w[atf_pkg::ST_ERR] = !busy_w && err_sum_reg;
    end

    // ----------------------------------------
    // activity and presence
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive1_reg <= 1'b0;
            strap_done_reg <= 1'b0;
            prs_cnt_reg <= 24'h000000;
        end else if (!strap_done_reg) begin
            drive1_reg <= drive1_i;
            strap_done_reg <= 1'b1;
            prs_cnt_reg <= drive1_i ? 24'(PRESENCE_CYC) : 24'h000000;
        end else if (prs_cnt_reg != 24'h000000) begin
            prs_cnt_reg <= prs_cnt_reg - 24'h000001;
        end
    end
    assign dasp_o = 1'b0;
    assign dasp_oe_n_o = !(state_reg != atf_pkg::ST_IDLE
        || prs_cnt_reg != 24'h000000);

    // ----------------------------------------
    // data buffers and DMA request
    // ----------------------------------------
    atf_fifo #(.W(atf_pkg::FIFO_W), .D(atf_pkg::FIFO_D)) u_rd_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(eng_rvalid_i),
        .in_ready_o(eng_rready_o),
        .in_data_i(eng_rdata_i),
        .out_valid_o(rf_valid),
        .out_ready_i(rf_pop),
        .out_data_o(rf_data)
    );
    atf_fifo #(.W(atf_pkg::FIFO_W), .D(atf_pkg::FIFO_D)) u_wr_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(wf_push),
        .in_ready_o(wf_ready),
        .in_data_i(dd_i),
        .out_valid_o(eng_wvalid_o),
        .out_ready_i(eng_wready_i),
        .out_data_o(eng_wdata_o)
    );
    assign dmarq_o = state_reg == atf_pkg::ST_DMA
        && (dma_rd_reg ? rf_valid : wf_ready);

    // ----------------------------------------
    // engine-side views
    // ----------------------------------------
    assign cmd_code_o = code_reg;
    assign feature_o = feat_reg;
    assign sect_cnt_o = sc_reg;
    assign sect_num_o = sn_reg;
    assign cyl_o = {ch_reg, cl_reg};
    assign head_o = dh_reg[3:0];
    assign lba_mode_o = dh_reg[atf_pkg::DH_LBA];
    assign lba_o = {dh_reg[3:0], ch_reg, cl_reg, sn_reg};
    assign srst_o = srst;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    localparam int SETTLE_L = atf_pkg::SETTLE_CYC;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_done;
        done_ok && !srst;
    endsequence
    sequence s_stat_rd;
        rd_serve && sel_cmd && da_i == atf_pkg::DA_STAT_CMD && !done_ok;
    endsequence
    AST_DASP_CMD: assert property (cmd_go |=> !dasp_oe_n_o)
        else $error("activity not shown on command");
    AST_PRESENCE: assert property ($rose(strap_done_reg) && drive1_reg
        |-> !dasp_oe_n_o [*8])
        else $error("drive 1 presence missing");
    AST_DMARQ: assert property (dmarq_o |-> state_reg ==
        atf_pkg::ST_DMA && (rf_valid || wf_ready))
        else $error("dma request while not ready");
    AST_BOTH_CS: assert property (!cs0_n_i && !cs1_n_i && dmack_n_i
        |-> dd_oe_n_o)
        else $error("bus driven on invalid address");
    AST_ERR_SUM: assert property (s_done |=> status_w[atf_pkg::ST_ERR]
        == (err_reg != 8'h00))
        else $error("error summary mismatch");
    AST_SC_LEFT: assert property (s_done |=> sc_reg == $past(done_sc_i)
        && dh_reg[3:0] == $past(done_head_i))
        else $error("count or head not updated");
    AST_INT_ACK: assert property (s_stat_rd |=> !pend_reg)
        else $error("status read kept interrupt");
    AST_INT_EN: assert property (ctl_reg[atf_pkg::CTL_IDIS]
        |-> intrq_oe_n_o)
        else $error("interrupt driven while disabled");
    AST_SETTLE: assert property (s_done ##1 $fell(busy_w) |->
        ##[0:SETTLE_L] status_w[atf_pkg::ST_ERR]
        == (err_reg != 8'h00))
        else $error("status not valid after busy");
    AST_NOT_ME: assert property (wr_serve && sel_cmd && !me
        && da_i == atf_pkg::DA_ERR_FEAT |=> $stable(feat_reg))
        else $error("write taken for other drive");
endmodule

//--- testbench/ata_task_file_interface_test.sv
`timescale 1ns/1ps
module ata_task_file_interface_test;
    localparam int PRES = 16;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic drive1_i = 1'b1;
    logic done_i = 1'b0;
    logic [7:0] done_err_i = 8'h00, done_sc_i = 8'h00, done_sn_i = 8'h00;
    logic [15:0] done_cyl_i = 16'h0000, eng_rdata_i = 16'h0000;
    logic [3:0] done_head_i = 4'h0;
    logic eng_rvalid_i = 1'b0;
    logic eng_wready_i = 1'b1;
    logic cs0_n, cs1_n, rd_n, wr_n, dmack_n, dd_oe_n, iordy, dmarq;
    logic [2:0] da;
    logic [15:0] h_dd, d_dd, dd_w, cyl_o, eng_wdata_o;
    logic intrq_o, intrq_oe_n_o, dasp_o, dasp_oe_n_o, dasp_w, cmd_valid_o;
    logic [7:0] cmd_code_o, feature_o, sect_cnt_o, sect_num_o;
    logic [3:0] head_o;
    logic lba_mode_o, srst_o, eng_rready_o, eng_wvalid_o;
    logic [27:0] lba_o;
    logic [31:0] seed = 32'h00010803;
    int errors = 0, n_checks = 0, ncmd = 0, cyc = 0;
    logic [15:0] q[$], wq[$], pq[$];
    logic [7:0] v, sc, sn, cl, ch;
    logic [3:0] hd;
    logic [15:0] r;
    logic g;
    assign dd_w = dd_oe_n ? h_dd : d_dd;
    assign dasp_w = dasp_oe_n_o ? 1'b1 : dasp_o;
    always #25 clk_i = ~clk_i;
    atf_host_model host (.clk_i(clk_i), .dd_i(dd_w), .dd_oe_n_i(dd_oe_n),
        .iordy_i(iordy), .dmarq_i(dmarq), .cs0_n_o(cs0_n), .cs1_n_o(cs1_n),
        .da_o(da), .rd_n_o(rd_n), .wr_n_o(wr_n), .dd_o(h_dd),
        .dmack_n_o(dmack_n));
    atf_task_file #(.PRESENCE_CYC(PRES)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .cs0_n_i(cs0_n), .cs1_n_i(cs1_n), .da_i(da), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .dd_i(dd_w), .dd_o(d_dd), .dd_oe_n_o(dd_oe_n),
        .iordy_o(iordy), .intrq_o(intrq_o), .intrq_oe_n_o(intrq_oe_n_o),
        .dasp_o(dasp_o), .dasp_oe_n_o(dasp_oe_n_o), .dmarq_o(dmarq),
        .dmack_n_i(dmack_n), .drive1_i(drive1_i), .cmd_valid_o(cmd_valid_o),
        .cmd_code_o(cmd_code_o), .feature_o(feature_o),
        .sect_cnt_o(sect_cnt_o), .sect_num_o(sect_num_o), .cyl_o(cyl_o),
        .head_o(head_o), .lba_mode_o(lba_mode_o), .lba_o(lba_o),
        .srst_o(srst_o), .eng_ready_i(1'b1), .pio_req_i(1'b0),
        .done_i(done_i), .done_err_i(done_err_i), .done_sc_i(done_sc_i),
        .done_sn_i(done_sn_i), .done_cyl_i(done_cyl_i),
        .done_head_i(done_head_i), .eng_rdata_i(eng_rdata_i),
        .eng_rvalid_i(eng_rvalid_i), .eng_rready_o(eng_rready_o),
        .eng_wdata_o(eng_wdata_o), .eng_wvalid_o(eng_wvalid_o),
        .eng_wready_i(eng_wready_i));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic errsum(input logic [7:0] e);
        return e != 8'h00;
    endfunction
    task automatic chk(input string s, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic wr(input logic c, input logic [2:0] a, input logic [7:0] d);
        host.acc(1'b1, c, ~c, a, {8'h00, d}, 1'b0, r, g);
    endtask
    task automatic rd(input logic c, input logic [2:0] a, output logic [7:0] d);
        host.acc(1'b0, c, ~c, a, 16'h0000, 1'b0, r, g);
        d = r[7:0];
    endtask
    task automatic rb(input logic [7:0] x2, x3, x4, x5);
        rd(1'b0, 3'h2, v);
        chk("sect_cnt", v, x2);
        rd(1'b0, 3'h3, v);
        chk("sect_num", v, x3);
        rd(1'b0, 3'h4, v);
        chk("cyl_low", v, x4);
        rd(1'b0, 3'h5, v);
        chk("cyl_high", v, x5);
    endtask
    task automatic cmd(input logic [7:0] c);
        int n0;
        n0 = ncmd;
        wr(1'b0, 3'h7, c);
        @(negedge clk_i);
        chk("cmd_pulse", ncmd, n0 + 1);
        chk("cmd_code", cmd_code_o, c);
        chk("active", dasp_w, 1'b0);
    endtask
    task automatic fin(input logic [7:0] e);
        @(posedge clk_i);
        done_i <= 1'b1;
        done_err_i <= e;
        done_sc_i <= 8'(xs());
        done_sn_i <= 8'(xs());
        done_cyl_i <= 16'(xs());
        done_head_i <= 4'(xs());
        @(posedge clk_i);
        done_i <= 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cmd_valid_o === 1'b1)
            ncmd++;
        if (eng_wvalid_o === 1'b1 && eng_wready_i)
            wq.push_back(eng_wdata_o);
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk("presence", dasp_w, 1'b0);
        repeat (PRES + 2) @(posedge clk_i);
        @(negedge clk_i);
        chk("presence_end", dasp_w, 1'b1);
        rd(1'b0, 3'h1, v);
        chk("diag", v, atf_pkg::DIAG_PASS);
        rb(8'h01, 8'h01, 8'h00, 8'h00);
        wr(1'b0, 3'h6, 8'h00);
        chk("not_sel", intrq_oe_n_o, 1'b1);
        wr(1'b0, 3'h2, 8'hab);
        wr(1'b0, 3'h1, 8'h5a);
        chk("feat_other", feature_o, 8'h00);
        wr(1'b0, 3'h6, 8'h10);
        chk("sel", intrq_oe_n_o, 1'b0);
        rd(1'b0, 3'h2, v);
        chk("other_drive", v, 8'h01);
        wr(1'b1, 3'h6, 8'h02);
        chk("int_off", intrq_oe_n_o, 1'b1);
        wr(1'b1, 3'h6, 8'h00);
        chk("int_on", intrq_oe_n_o, 1'b0);
        for (int i = 0; i < 4; i++) begin
            {sc, sn, cl, ch} = xs();
            hd = 4'(xs());
            wr(1'b0, 3'h2, sc);
            wr(1'b0, 3'h3, sn);
            wr(1'b0, 3'h4, cl);
            wr(1'b0, 3'h5, ch);
            wr(1'b0, 3'h6, {1'b0, i[0], 2'b01, hd});
            chk("lba_mode", lba_mode_o, i[0]);
            chk("lba", lba_o, {hd, ch, cl, sn});
            chk("cyl", cyl_o, {ch, cl});
            chk("head", head_o, hd);
            chk("sect_out", {sect_cnt_o, sect_num_o}, {sc, sn});
            rb(sc, sn, cl, ch);
            rd(1'b0, 3'h6, v);
            chk("dev_head", v & 8'h5f, {2'b00, i[0], 2'b01, hd});
        end
        for (int a = 0; a < 8; a++) begin
            if (a != 6) begin
                host.acc(1'b0, 1'b1, 1'b0, 3'(a), 16'h0000, 1'b0, r, g);
                chk("unused", g, 1'b0);
            end
        end
        host.acc(1'b0, 1'b0, 1'b0, 3'h7, 16'h0000, 1'b0, r, g);
        chk("both_cs", g, 1'b0);
        for (int b = 0; b < 8; b++) begin
            v = 8'(xs());
            wr(1'b0, 3'h1, v);
            chk("feature", feature_o, v);
            cmd(8'h10);
            rd(1'b1, 3'h6, v);
            chk("busy", v[atf_pkg::ST_BUSY], 1'b1);
            fin(8'h01 << b);
            repeat (atf_pkg::SETTLE_CYC) @(posedge clk_i);
            @(negedge clk_i);
            chk("inactive", dasp_w, 1'b1);
            chk("irq", intrq_o, 1'b1);
            rd(1'b0, 3'h1, v);
            chk("error", v, done_err_i & atf_pkg::ER_USED);
            rd(1'b1, 3'h6, v);
            chk("not_busy", v[atf_pkg::ST_BUSY], 1'b0);
            chk("err_sum", v[0], errsum(done_err_i & atf_pkg::ER_USED));
            chk("irq_alt", intrq_o, 1'b1);
            rd(1'b0, 3'h7, v);
            chk("irq_ack", intrq_o, 1'b0);
            rb(done_sc_i, done_sn_i, done_cyl_i[7:0], done_cyl_i[15:8]);
            rd(1'b0, 3'h6, v);
            chk("head_done", v[3:0], done_head_i);
        end
        cmd(atf_pkg::CMD_DMA_RD);
        @(posedge clk_i);
        eng_rvalid_i <= 1'b1;
        eng_rdata_i <= 16'(xs());
        repeat (40) begin
            @(posedge clk_i);
            if (eng_rready_o === 1'b1)
                q.push_back(eng_rdata_i);
            eng_rdata_i <= 16'(xs());
        end
        eng_rvalid_i <= 1'b0;
        @(negedge clk_i);
        chk("fill", q.size(), atf_pkg::FIFO_D);
        chk("full", eng_rready_o, 1'b0);
        chk("dmarq", dmarq, 1'b1);
        foreach (q[i]) begin
            host.acc(1'b0, 1'b1, 1'b1, 3'h0, 16'h0000, 1'b1, r, g);
            chk("dma_rd", r, q[i]);
        end
        repeat (2) @(posedge clk_i);
        chk("dmarq_empty", dmarq, 1'b0);
        fin(8'hc0);
        rd(1'b0, 3'h1, v);
        chk("error_mw", v, 8'hc0 & atf_pkg::ER_USED_MW);
        cmd(atf_pkg::CMD_DMA_WR);
        repeat (2) begin
            pq.push_back(16'(xs()));
            host.acc(1'b1, 1'b1, 1'b1, 3'h0, pq[$], 1'b1, r, g);
        end
        repeat (4) @(posedge clk_i);
        chk("dma_wr_n", wq.size(), 2);
        foreach (pq[i])
            chk("dma_wr", wq[i], pq[i]);
        fin(8'h00);
        wr(1'b1, 3'h6, 8'h04);
        chk("srst", srst_o, 1'b1);
        wr(1'b1, 3'h6, 8'h00);
        rd(1'b0, 3'h1, v);
        chk("diag_srst", v, atf_pkg::DIAG_PASS);
        test_done();
    end
endmodule

//--- testbench/atf_host_model.sv
`timescale 1ns/1ps
module atf_host_model (
    input wire logic clk_i,
    input wire logic [15:0] dd_i,
    input wire logic dd_oe_n_i,
    input wire logic iordy_i,
    input wire logic dmarq_i,
    output logic cs0_n_o,
    output logic cs1_n_o,
    output logic [2:0] da_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [15:0] dd_o,
    output logic dmack_n_o
);
    // ----------------------------------------
    // idle bus
    // ----------------------------------------
    initial begin
        cs0_n_o = 1'b1;
        cs1_n_o = 1'b1;
        da_o = 3'h0;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        dd_o = 16'hffff;
        dmack_n_o = 1'b1;
    end
    // ----------------------------------------
    // one register or dma access
    // ----------------------------------------
    task automatic acc(input logic we, input logic c0, input logic c1,
        input logic [2:0] a, input logic [15:0] wd, input logic dma,
        output logic [15:0] rd, output logic got);
        int n;
        n = 0;
        @(posedge clk_i);
        while (dma && dmarq_i !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        dmack_n_o <= ~dma;
        cs0_n_o <= c0;
        cs1_n_o <= c1;
        da_o <= a;
        dd_o <= wd;
        wr_n_o <= ~we;
        rd_n_o <= we;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((we ? iordy_i : ~dd_oe_n_i) !== 1'b1 && n < 10);
        got = (we ? iordy_i : ~dd_oe_n_i) === 1'b1;
        rd = dd_i;
        rd_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        cs0_n_o <= 1'b1;
        cs1_n_o <= 1'b1;
        dmack_n_o <= 1'b1;
        dd_o <= ~wd;
        @(posedge clk_i);
    endtask
endmodule
